// >>> logic/serial_map.svh
`ifndef SERIAL_MAP_SVH
`define SERIAL_MAP_SVH

// ****************************************
// Register word indices (byte address = 4 x index)
// ****************************************
`define IDX_CTL_ONE  14'h0F95
`define IDX_CTL_TWO  14'h0F96
`define IDX_DATA     14'h0F97
`define IDX_INT_STAT 14'h0F98
`define IDX_INT_MASK 14'h0F99

// ****************************************
// Field positions and reset values
// ****************************************
`define B_TX_EN      7
`define B_RX_EN      6
`define B_TX_STOP    5
`define B_EVEN       4
`define B_PAR_ON     3
`define CTL_ONE_RST  8'h00
`define CTL_TWO_RST  3'h0
`define INT_RST      3'h0

// ****************************************
// Baud divisors, in main clock periods per oversample tick
// ****************************************
`define DIV_0        9'h00D
`define DIV_1        9'h01A
`define DIV_2        9'h034
`define DIV_3        9'h068
`define DIV_4        9'h0D0
`define DIV_5        9'h1A0
`define DIV_7        9'h060
`define RATE_TIMER   3'h6

// ****************************************
// Noise filter widths, in main clock periods
// ****************************************
`define FLT_1        7'h1F
`define FLT_2        7'h3F
`define FLT_3        7'h7F

// ****************************************
// Oversampling positions within one bit
// ****************************************
`define OVS_LAST     4'hF
`define SMP_FIRST    4'h7
`define SMP_LAST     4'h9

`endif

// >>> logic/serial_pkg.sv
package serial_pkg;
	typedef enum logic [2:0] {tx_idle, tx_start, tx_data, tx_par, tx_stop} tx_state_type;
	typedef enum logic [2:0] {rx_idle, rx_start, rx_data, rx_par, rx_stop} rx_state_type;
endpackage

// >>> logic/async_serial_control.sv
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "serial_map.svh"
module async_serial_control import serial_pkg::*; #(
	parameter int DATA_BITS = 8
)(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [15:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Serial pins and timer event
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	input  wire logic        timer_three_match,
	// Interrupt
	output logic             irq
);
	localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);
	logic         [7:0] ctl_one_r, tx_hold_r, rx_buf_r, rx_sh_r;
	logic         [2:0] ctl_two_r, int_stat_r, int_mask_r;
	logic         [8:0] div_cnt_r;
	logic         [6:0] flt_cnt_r;
	tx_state_type       tx_st_r;
	rx_state_type       rx_st_r;
	logic         [3:0] tcnt_r, rcnt_r;
	logic         [2:0] tbit_r, rbit_r, smp_r;
	logic               perr_r, ferr_r, oerr_r, rx_full_r, tx_done_r, tx_empty_r;
	logic               sr_seen_r, rx_filt_r;
	logic               tx_en_eff_r, rx_en_eff_r, tx_pend_r;
	logic               perr_l_r, ferr_l_r, rx_fin_r;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// ****************************************
	// Bus decode
	// ****************************************
	wire [13:0] idx      = wb_adr_i[15:2];
	wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wr       = req & wb_we_i & wb_sel_i[0];
	wire        rd       = req & ~wb_we_i;
	wire        hit_one  = idx == `IDX_CTL_ONE;
	wire        hit_two  = idx == `IDX_CTL_TWO;
	wire        hit_data = idx == `IDX_DATA;
	wire        hit_ist  = idx == `IDX_INT_STAT;
	wire        hit_msk  = idx == `IDX_INT_MASK;
	wire        rd_rxbuf = rd & hit_data;
	wire        rx_clr   = rd_rxbuf & sr_seen_r;
	wire [7:0]  status   = {perr_r, ferr_r, oerr_r, rx_full_r, tx_done_r, tx_empty_r, 2'b00};
	wire [7:0]  rd_val   = hit_one  ? status :
	                       hit_data ? rx_buf_r :
	                       hit_ist  ? {5'h00, int_stat_r} :
	                       hit_msk  ? {5'h00, int_mask_r} : 8'h00;

	// Control registers are write only; a read of control one shows status
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctl_one_r  <= `CTL_ONE_RST;
			ctl_two_r  <= `CTL_TWO_RST;
			int_mask_r <= `INT_RST;
		end else if (wr) begin
			if (hit_one) ctl_one_r <= wb_dat_i[7:0];
			if (hit_two) ctl_two_r <= wb_dat_i[2:0];
			if (hit_msk) int_mask_r <= wb_dat_i[2:0];
		end
	end

	// Single wait state: answer one cycle after the request
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= 32'h0000_0000;
			sr_seen_r <= 1'b0;
		end else begin
			wb_ack_o <= req;
			if (rd) wb_dat_o <= {24'h00_0000, rd_val};
			if (req) sr_seen_r <= rd & hit_one;
		end
	end

	// ****************************************
	// Baud tick, shared by both directions
	// ****************************************
	wire [2:0] rate_select = ctl_one_r[2:0];
	wire       parity_on   = ctl_one_r[`B_PAR_ON];
	wire       par_even    = ctl_one_r[`B_EVEN];
	wire [8:0] div_max     = rate_select == 3'h0 ? `DIV_0 :
	                         rate_select == 3'h1 ? `DIV_1 :
	                         rate_select == 3'h2 ? `DIV_2 :
	                         rate_select == 3'h3 ? `DIV_3 :
	                         rate_select == 3'h4 ? `DIV_4 :
	                         rate_select == 3'h5 ? `DIV_5 : `DIV_7;
	wire       div_hit     = div_cnt_r >= div_max - 9'h001;
	wire       use_timer   = rate_select == `RATE_TIMER;
	wire       tick        = use_timer ? timer_three_match : div_hit;

	// Compare with >= so a rate change never strands the counter
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) div_cnt_r <= 9'h000;
		else if (div_hit) div_cnt_r <= 9'h000;
		else div_cnt_r <= div_cnt_r + 9'h001;
	end

	// ****************************************
	// Receive noise filter
	// ****************************************
	wire [1:0] noise_filter_sel = ctl_two_r[2:1];
	wire [6:0] flt_max = noise_filter_sel == 2'h1 ? `FLT_1 :
	                     noise_filter_sel == 2'h2 ? `FLT_2 : `FLT_3;

	// With the filter on, pulses shorter than the window never reach the receiver
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_filt_r <= 1'b1;
			flt_cnt_r <= 7'h00;
		end else if (noise_filter_sel == 2'h0) begin
			rx_filt_r <= serial_in_pin;
			flt_cnt_r <= 7'h00;
		end else if (serial_in_pin == rx_filt_r) begin
			flt_cnt_r <= 7'h00;
		end else if (flt_cnt_r >= flt_max - 7'h01) begin
			rx_filt_r <= serial_in_pin;
			flt_cnt_r <= 7'h00;
		end else begin
			flt_cnt_r <= flt_cnt_r + 7'h01;
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	wire t_end   = tick & (tcnt_r == `OVS_LAST);
	wire tx_go   = (tx_st_r == tx_idle) & tx_en_eff_r & tx_pend_r & tick;
	wire par_bit = ^tx_hold_r ^ ~par_even;
	wire tx_bit  = tx_st_r == tx_start ? 1'b0 :
	               tx_st_r == tx_data  ? tx_hold_r[tbit_r] :
	               tx_st_r == tx_par   ? par_bit : 1'b1;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_hold_r <= 8'h00;
			tx_pend_r <= 1'b0;
			tx_en_eff_r <= 1'b0;
		end else begin
			if (tx_st_r == tx_idle) tx_en_eff_r <= ctl_one_r[`B_TX_EN];
			if (wr & hit_data) tx_hold_r <= wb_dat_i[7:0];
			if (wr & hit_data & ctl_one_r[`B_TX_EN]) tx_pend_r <= 1'b1;
			else if (tx_go | ~ctl_one_r[`B_TX_EN]) tx_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_st_r <= tx_idle;
			tcnt_r  <= 4'h0;
			tbit_r  <= 3'h0;
		end else begin
			if (tx_st_r == tx_idle) tcnt_r <= 4'h0;
			else if (tick) tcnt_r <= tcnt_r + 4'h1;
			case (tx_st_r)
				tx_idle: if (tx_go) tx_st_r <= tx_start;
				tx_start: if (t_end) begin
					tx_st_r <= tx_data;
					tbit_r  <= 3'h0;
				end
				tx_data: if (t_end) begin
					tbit_r <= tbit_r + 3'h1;
					if (tbit_r == LAST_BIT) begin
						tx_st_r <= parity_on ? tx_par : tx_stop;
						tbit_r  <= 3'h0;
					end
				end
				tx_par: if (t_end) tx_st_r <= tx_stop;
				tx_stop: if (t_end) begin
					if (tbit_r == 3'h0 && ctl_one_r[`B_TX_STOP]) tbit_r <= 3'h1;
					else tx_st_r <= tx_idle;
				end
				default: tx_st_r <= tx_idle;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) serial_out_pin <= 1'b1;
		else serial_out_pin <= tx_bit;
	end

	// ****************************************
	// Receiver
	// ****************************************
	wire r_end = tick & (rcnt_r == `OVS_LAST);
	wire maj   = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);
	wire r_smp = tick & (rcnt_r >= `SMP_FIRST) & (rcnt_r <= `SMP_LAST);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_st_r <= rx_idle;
			rcnt_r  <= 4'h0;
			rbit_r  <= 3'h0;
			smp_r   <= 3'h7;
			rx_sh_r <= 8'h00;
			perr_l_r <= 1'b0;
			ferr_l_r <= 1'b0;
			rx_fin_r <= 1'b0;
			rx_en_eff_r <= 1'b0;
		end else begin
			rx_fin_r <= 1'b0;
			if (rx_st_r == rx_idle) rx_en_eff_r <= ctl_one_r[`B_RX_EN];
			if (rx_st_r != rx_idle && tick) rcnt_r <= rcnt_r + 4'h1;
			if (r_smp) smp_r <= {smp_r[1:0], rx_filt_r};
			case (rx_st_r)
				// Overrun holds reception off until the flag is cleared
				rx_idle: if (rx_en_eff_r & ~oerr_r & tick & ~rx_filt_r) begin
					rx_st_r  <= rx_start;
					rcnt_r   <= 4'h1;
					perr_l_r <= 1'b0;
					ferr_l_r <= 1'b0;
				end
				rx_start: if (r_end) begin
					rx_st_r <= maj ? rx_idle : rx_data;
					rbit_r  <= 3'h0;
				end
				rx_data: if (r_end) begin
					rx_sh_r[rbit_r] <= maj;
					rbit_r <= rbit_r + 3'h1;
					if (rbit_r == LAST_BIT) begin
						rx_st_r <= parity_on ? rx_par : rx_stop;
						rbit_r  <= 3'h0;
					end
				end
				rx_par: if (r_end) begin
					perr_l_r <= maj != (^rx_sh_r ^ ~par_even);
					rx_st_r  <= rx_stop;
				end
				rx_stop: if (r_end) begin
					if (!maj) ferr_l_r <= 1'b1;
					if (rbit_r == 3'h0 && ctl_two_r[0]) rbit_r <= 3'h1;
					else begin
						rx_st_r  <= rx_idle;
						rx_fin_r <= 1'b1;
					end
				end
				default: rx_st_r <= rx_idle;
			endcase
		end
	end

	// ****************************************
	// Status flags and interrupt; hardware set wins over clear
	// ****************************************
	wire [2:0] ev = {rx_fin_r & (perr_l_r | ferr_l_r | (rx_full_r & ~rx_clr)), rx_fin_r, tx_go};
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{perr_r, ferr_r, oerr_r, rx_full_r} <= 4'h0;
			{tx_done_r, tx_empty_r}             <= 2'b11;
			rx_buf_r <= 8'h00;
		end else begin
			if (rx_clr) {perr_r, ferr_r, oerr_r, rx_full_r} <= 4'h0;
			if (wr & hit_data & ctl_one_r[`B_TX_EN]) tx_empty_r <= 1'b0;
			if (tx_go) tx_empty_r <= 1'b1;
			tx_done_r <= tx_st_r == tx_idle;
			if (rx_fin_r & rx_full_r & ~rx_clr) oerr_r <= 1'b1; // Old data kept
			else if (rx_fin_r) begin
				rx_buf_r  <= rx_sh_r;
				rx_full_r <= 1'b1;
				perr_r   <= perr_l_r;
				ferr_r   <= ferr_l_r;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			int_stat_r <= `INT_RST;
			irq        <= 1'b0;
		end else begin
			int_stat_r <= ((rd & hit_ist) ? 3'h0 : int_stat_r) | ev;
			irq        <= |(int_stat_r & int_mask_r);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence bit_done;
		tick && tcnt_r == `OVS_LAST;
	endsequence

	idle_high_a: assert property (tx_st_r == tx_idle |=> serial_out_pin)
		else $error("output not high while idle");
	start_low_a: assert property (tx_st_r == tx_start |=> !serial_out_pin)
		else $error("start bit not low");
	frame_hold_a: assert property (tx_st_r != tx_idle |-> tx_en_eff_r)
		else $error("transmit enable dropped mid frame");
	stale_data_a: assert property ($rose(tx_en_eff_r) && !tx_pend_r |=> tx_st_r == tx_idle)
		else $error("stale buffer sent");
	timer_tick_a: assert property (use_timer && !timer_three_match |-> !tick)
		else $error("tick without timer match");
	filter_len_a: assert property (noise_filter_sel == 2'h1 && $past(noise_filter_sel) == 2'h1
		&& $changed(rx_filt_r) |-> $past(flt_cnt_r) == 7'h1E)
		else $error("filter passed a short pulse");
	raw_pass_a: assert property (noise_filter_sel == 2'h0 |=> rx_filt_r == $past(serial_in_pin))
		else $error("unfiltered input not passed");
	stop_two_a: assert property (tx_st_r == tx_stop && tbit_r == 3'h0 && ctl_one_r[`B_TX_STOP]
		##0 bit_done |=> tx_st_r == tx_stop)
		else $error("second stop bit missing");
	parity_out_a: assert property (tx_st_r == tx_par |=> serial_out_pin == $past(par_bit))
		else $error("wrong parity bit");
	irq_level_a: assert property (|(int_stat_r & int_mask_r) |=> irq)
		else $error("interrupt not raised");
endmodule

// >>> verification/remote_uart.sv
`timescale 1ns/1ps
// ****
// Remote transceiver
// ****
module remote_uart (
	// Clock
	input  wire logic mclk,
	// Link
	output logic      line_o,
	input  wire logic line_i
);
	// Idle high: a pulled-up line between frames
	initial line_o = 1'b1;
	task automatic send(input logic [11:0] f, input int n, input int bt);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk) line_o <= f[i];
			repeat (bt - 1) @(posedge mclk);
		end
		@(posedge mclk) line_o <= 1'b1;
	endtask
	// Samples mid-bit; bits past the frame read the idle level
	task automatic grab(output logic [11:0] f, input int bt, output bit ok);
		int k;
		f = 12'hFFF;
		k = 0;
		while (line_i !== 1'b0 && k < 20000) begin
			@(posedge mclk);
			k++;
		end
		ok = (k < 20000);
		repeat (bt / 2) @(posedge mclk);
		for (int i = 0; i < 12; i++) begin
			f[i] = line_i;
			repeat (bt) @(posedge mclk);
		end
	endtask
endmodule

// >>> verification/test_async_serial_control.sv
`timescale 1ns/1ps
`include "serial_map.svh"
module test_async_serial_control;
	logic        mclk, rst, cyc, stb, we, t3, tmr_on, sin, sout, irq, ack;
	logic [15:0] adr;
	logic [31:0] dw, dr, seed;
	logic [7:0]  q, d;
	logic [11:0] f;
	logic [3:0]  sel;
	logic [7:0]  exp_q [$];
	logic [7:0]  cf [4] = '{8'h80, 8'hA9, 8'h9F, 8'hBE};
	int          dv [8] = '{13, 26, 52, 104, 208, 416, 5, 96};
	integer      bad_count, n_compared, n, bt;
	integer      tcnt = 0;
	bit          ok;
	async_serial_control dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
		.wb_ack_o(ack), .serial_in_pin(sin), .serial_out_pin(sout),
		.timer_three_match(t3), .irq(irq));
	remote_uart far (.mclk(mclk), .line_o(sin), .line_i(sout));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Timer three stand-in: one match every 5 clocks
	always @(posedge mclk) begin
		tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
		t3   <= tmr_on && tcnt == 4;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected frame, LSB first; stop bits and idle read high
	function automatic logic [11:0] frame(input logic [7:0] v, input logic par, input logic ev);
		logic [11:0] x;
		x = {3'b111, v, 1'b0};
		if (par) begin
			x[9] = ev ? ^v : ~^v;
		end
		return x;
	endfunction
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic tmo(input bit fail);
		if (fail) begin
			bad_count++;
			report_and_stop();
		end
	endtask
	task automatic bus(input int w, input logic [13:0] a, input int v);
		int k;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w[0];
		sel <= 4'hF;
		adr <= {a, 2'b00};
		dw  <= {24'h0, v[7:0]};
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = dr[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		tmo(ack !== 1'b1);
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge mclk);
	endtask
	initial begin
		bad_count = 0;
		n_compared = 0;
		seed = 32'h00D817F9;
		{cyc, stb, we, sel, adr, dw, tmr_on} = '0;
		rst = 1'b1;
		wt(10);
		rst <= 1'b0;
		chk({11'h0, sout}, 12'h001);
		chk({11'h0, irq}, 12'h000);
		bus(0, `IDX_CTL_ONE, 0);
		chk({4'h0, q}, 12'h00C);
		bus(0, 14'h0F9A, 0);
		chk({4'h0, q}, 12'h000);
		$display("test reset done");
		bus(1, `IDX_DATA, 8'hA5);
		bus(1, `IDX_CTL_ONE, 8'h80);
		n = 0;
		repeat (3000) begin
			@(posedge mclk);
			if (sout !== 1'b1) n++;
		end
		chk(n[11:0], 12'h000);
		$display("test stale buffer done");
		for (int i = 0; i < 4; i++) begin
			bus(1, `IDX_CTL_ONE, 8'h00);
			tmr_on <= (i == 3);
			bus(1, `IDX_CTL_ONE, cf[i]);
			seed = lfsr(seed);
			d = seed[7:0];
			exp_q.push_back(d);
			bt = dv[cf[i][2:0]] * 16;
			fork
				far.grab(f, bt, ok);
				begin
					bus(1, `IDX_DATA, d);
					// Disable mid-frame; format bits kept
					if (i == 3) begin
						wt(300);
						bus(1, `IDX_CTL_ONE, 8'h3E);
					end
				end
			join
			tmo(!ok);
			chk(f, frame(exp_q.pop_front(), cf[i][3], cf[i][4]));
			$display("test format %0d done", i);
		end
		tmr_on <= 1'b0;
		bus(1, `IDX_CTL_ONE, 8'h00);
		bus(1, `IDX_CTL_TWO, 8'h03);
		bus(1, `IDX_CTL_ONE, 8'h48);
		bus(0, `IDX_INT_STAT, 0);
		seed = lfsr(seed);
		d = seed[7:0];
		exp_q.push_back(d);
		far.send(frame(d, 1'b1, 1'b0), 12, 208);
		wt(200);
		chk({11'h0, irq}, 12'h000);
		bus(1, `IDX_INT_MASK, 8'h02);
		wt(3);
		chk({11'h0, irq}, 12'h001);
		bus(0, `IDX_CTL_ONE, 0);
		chk({4'h0, q}, 12'h01C);
		bus(0, `IDX_DATA, 0);
		chk({4'h0, q}, {4'h0, exp_q.pop_front()});
		bus(0, `IDX_INT_STAT, 0);
		chk({4'h0, q}, 12'h002);
		wt(3);
		chk({11'h0, irq}, 12'h000);
		$display("test receive done");
		far.send(12'h000, 1, 20);
		wt(3000);
		bus(0, `IDX_CTL_ONE, 0);
		chk({4'h0, q}, 12'h00C);
		$display("test noise done");
		// Filter code 10, one stop bit; bits of 208 clocks exceed the 63 floor
		bus(1, `IDX_CTL_TWO, 8'h04);
		seed = lfsr(seed);
		d = seed[7:0];
		exp_q.push_back(d);
		// Even parity bit against the odd setting
		far.send(frame(d, 1'b1, 1'b1), 12, 208);
		wt(200);
		bus(0, `IDX_CTL_ONE, 0);
		chk({4'h0, q}, 12'h09C);
		bus(0, `IDX_DATA, 0);
		chk({4'h0, q}, {4'h0, exp_q.pop_front()});
		bus(0, `IDX_INT_STAT, 0);
		chk({4'h0, q}, 12'h006);
		$display("test parity error done");
		report_and_stop();
	end
endmodule
